// ==== src/adc_ctrl_pkg.sv ====
// Purpose: shared constants and carrier types for the converter control block
// Assumes: 32-bit APB, one word per register
// Notes:   offsets are byte addresses
`default_nettype none
package adc_ctrl_pkg;
   localparam int CHANNELS = 4;
   localparam int RES_W    = 12;
   localparam int CAL_W    = 16;

   localparam logic [7:0] OFS_CTRL_A    = 8'h00;
   localparam logic [7:0] OFS_TRIG_CTRL = 8'h04;
   localparam logic [7:0] OFS_CMP_CTRL  = 8'h08;
   localparam logic [7:0] OFS_CMP_VALUE = 8'h0C;
   localparam logic [7:0] OFS_CAL       = 8'h10;
   localparam logic [7:0] OFS_INT_STAT  = 8'h14;
   localparam logic [7:0] OFS_INT_CLR   = 8'h18;
   localparam logic [7:0] OFS_INT_EN    = 8'h1C;
   localparam logic [7:0] OFS_RESULT0   = 8'h20;

   // first_control_register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_START_LSB  = 2;
   // trigger_control_register fields
   localparam int TRIG_FREE_BIT   = 0;
   localparam int TRIG_SWEEP_LSB  = 1;
   localparam int TRIG_EVSEL_LSB  = 4;
   // compare control fields
   localparam int CMP_EN_LSB      = 0;
   localparam int CMP_ABOVE_LSB   = 4;
   // interrupt layout: complete bits, then compare bits
   localparam int INT_CMP_LSB     = 4;

   localparam logic [1:0] SWEEP_CH0 = 2'h0;
   localparam logic [1:0] SWEEP_ALL = 2'h3;

   typedef struct packed {
      logic                 valid;
      logic [1:0]           channel;
      logic [RES_W-1:0]     data;
   } conv_result_type;

   typedef struct packed {
      logic                 start;
      logic [1:0]           channel;
      logic [CAL_W-1:0]     calibration;
   } conv_request_type;
endpackage
`default_nettype wire

// ==== src/adc_sweep_sequencer.sv ====
// Purpose: picks the next channel to convert from manual, event and sweep requests
// Assumes: one request issued per free converter slot
// Notes:   sweep order is ascending from channel 0
`default_nettype none
module adc_sweep_sequencer #(
   parameter int CH = 4
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          enable,
   input  wire logic          free_run,
   input  wire logic [1:0]    sweep_sel,
   input  wire logic [CH-1:0] new_req,
   input  wire logic          slot_free,
   output logic               issue,
   output logic [1:0]         issue_ch,
   output logic [CH-1:0]      pending
);
   logic [1:0] sweep_ch;
   logic [1:0] slot_ch;
   logic [CH-1:0] next_pending;
   logic [1:0] pick;
   logic       have;

   always_comb begin
      pick = 2'h0;
      have = 1'b0;
      for (int i = CH-1; i >= 0; i--) begin
         if (pending[i]) begin
            pick = 2'(i);
            have = 1'b1;
         end
      end
   end

   always_comb begin
      next_pending = pending | new_req;
      if (slot_free && have && !free_run)
         next_pending[pick] = new_req[pick];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pending <= '0;
      else if (!enable)
         pending <= '0;
      else
         pending <= next_pending;
   end

   // a group narrowed mid-sweep restarts at channel 0 rather than issue outside it
   assign slot_ch = (sweep_ch > sweep_sel) ? 2'h0 : sweep_ch;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         issue    <= 1'b0;
         issue_ch <= 2'h0;
         sweep_ch <= 2'h0;
      end else begin
         issue <= 1'b0;
         if (enable && slot_free && free_run) begin
            issue    <= 1'b1;
            issue_ch <= slot_ch;
            sweep_ch <= (slot_ch >= sweep_sel) ? 2'h0 : slot_ch + 2'h1;
         end else if (enable && slot_free && have) begin
            issue    <= 1'b1;
            issue_ch <= pick;
         end
         if (!free_run)
            sweep_ch <= 2'h0;
      end
   end
endmodule
`default_nettype wire

// ==== src/adc_sweep_compare_control.sv ====
// Purpose: APB control of a four-channel pipelined converter with sweep and comparator
// Assumes: converter returns one result per request, in request order
// Notes:   result registers overwrite on each conversion
//
// Chosen here: the register offsets and the APB interface to the registers.
`default_nettype none
module adc_sweep_compare_control #(
   parameter int CH    = adc_ctrl_pkg::CHANNELS,
   parameter int RES_W = adc_ctrl_pkg::RES_W
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          trigger_event,
   output adc_ctrl_pkg::conv_request_type     conv_req,
   output logic                               conv_enable,
   input  wire adc_ctrl_pkg::conv_result_type conv_res,
   output logic                               irq
);
   logic [31:0] ctrl_a;
   logic [31:0] trig_ctrl;
   logic [31:0] cmp_ctrl;
   logic [RES_W-1:0] cmp_value;
   logic [adc_ctrl_pkg::CAL_W-1:0] calibration;
   logic [2*CH-1:0] int_stat;
   logic [2*CH-1:0] int_en;
   logic [RES_W-1:0] result [CH];
   logic [CH-1:0] ready_flag;
   logic [CH-1:0] new_req;
   logic [CH-1:0] pending;
   logic          issue;
   logic [1:0]    issue_ch;
   logic          event_d;
   logic          wr_en;
   logic          rd_en;
   logic [CH-1:0] start_bits;
   logic [CH-1:0] sweep_mask;
   logic [2*CH-1:0] set_bits;
   logic [31:0]   next_prdata;
   logic          mapped;

   // channels in the group chosen by a sweep code
   function automatic logic [CH-1:0] sweep_group(input logic [1:0] sel);
      logic [CH-1:0] m;
      m = '0;
      for (int i = 0; i < CH; i++)
         m[i] = (2'(i) <= sel);
      return m;
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // byte address of one channel's result word
   function automatic logic [7:0] result_addr(input int ch);
      return adc_ctrl_pkg::OFS_RESULT0 + 8'(4 * ch);
   endfunction

   assign wr_en      = psel && penable && pwrite;
   assign rd_en      = psel && !penable && !pwrite;
   assign start_bits = ctrl_a[adc_ctrl_pkg::CTRL_START_LSB +: CH];
   assign sweep_mask = sweep_group(trig_ctrl[adc_ctrl_pkg::TRIG_SWEEP_LSB +: 2]);

   // register writes; start bits self-clear the cycle after they are written, taken or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a      <= '0;
         trig_ctrl   <= '0;
         cmp_ctrl    <= '0;
         cmp_value   <= '0;
         calibration <= '0;
         int_en      <= '0;
      end else begin
         ctrl_a[adc_ctrl_pkg::CTRL_START_LSB +: CH] <= '0;
         if (wr_en) begin
            if (is_addr(paddr, adc_ctrl_pkg::OFS_CTRL_A))
               ctrl_a <= pwdata & 32'h0000003D;
            if (is_addr(paddr, adc_ctrl_pkg::OFS_TRIG_CTRL))
               trig_ctrl <= pwdata & 32'h0000003F;
            if (is_addr(paddr, adc_ctrl_pkg::OFS_CMP_CTRL))
               cmp_ctrl <= pwdata & 32'h000000FF;
            if (is_addr(paddr, adc_ctrl_pkg::OFS_CMP_VALUE))
               cmp_value <= pwdata[RES_W-1:0];
            if (is_addr(paddr, adc_ctrl_pkg::OFS_CAL))
               calibration <= pwdata[adc_ctrl_pkg::CAL_W-1:0];
            if (is_addr(paddr, adc_ctrl_pkg::OFS_INT_EN))
               int_en <= pwdata[2*CH-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         event_d <= 1'b0;
      else
         event_d <= trigger_event;
   end

   always_comb begin
      new_req = start_bits;
      if (trigger_event && !event_d) begin
         if (trig_ctrl[adc_ctrl_pkg::TRIG_EVSEL_LSB +: 2] == adc_ctrl_pkg::SWEEP_ALL)
            new_req = new_req | sweep_mask;
         else
            new_req[trig_ctrl[adc_ctrl_pkg::TRIG_EVSEL_LSB +: 2]] = 1'b1;
      end
   end

   // the pipeline takes one request per clock, so a slot is always free
   // sweep group select
   adc_sweep_sequencer #(
      .CH (CH)
   ) sequencer (
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (ctrl_a[adc_ctrl_pkg::CTRL_ENABLE_BIT]),
      .free_run  (trig_ctrl[adc_ctrl_pkg::TRIG_FREE_BIT]),
      .sweep_sel (trig_ctrl[adc_ctrl_pkg::TRIG_SWEEP_LSB +: 2]),
      .new_req   (new_req),
      .slot_free (1'b1),
      .issue     (issue),
      .issue_ch  (issue_ch),
      .pending   (pending)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_req    <= '0;
         conv_enable <= 1'b0;
      end else begin
         conv_enable         <= ctrl_a[adc_ctrl_pkg::CTRL_ENABLE_BIT];
         conv_req.start      <= issue;
         conv_req.channel    <= issue_ch;
         conv_req.calibration <= calibration;
      end
   end

   // a read clears the flag at setup; a result landing in that cycle keeps it set
   // per-channel result store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < CH; i++)
            result[i] <= '0;
         ready_flag <= '0;
      end else begin
         for (int i = 0; i < CH; i++) begin
            if (rd_en && is_addr(paddr, result_addr(i)))
               ready_flag[i] <= 1'b0;
         end
         if (conv_res.valid) begin
            result[conv_res.channel]     <= conv_res.data;
            ready_flag[conv_res.channel] <= 1'b1;
         end
      end
   end

   always_comb begin
      set_bits = '0;
      if (conv_res.valid) begin
         if (cmp_ctrl[adc_ctrl_pkg::CMP_EN_LSB + conv_res.channel]) begin
            if (cmp_ctrl[adc_ctrl_pkg::CMP_ABOVE_LSB + conv_res.channel]
                ? (conv_res.data > cmp_value) : (conv_res.data < cmp_value))
               set_bits[adc_ctrl_pkg::INT_CMP_LSB + conv_res.channel] = 1'b1;
         end else begin
            set_bits[conv_res.channel] = 1'b1;
         end
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         int_stat <= '0;
      else if (wr_en && is_addr(paddr, adc_ctrl_pkg::OFS_INT_CLR))
         int_stat <= (int_stat & ~pwdata[2*CH-1:0]) | set_bits;
      else
         int_stat <= int_stat | set_bits;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(int_stat & int_en);
   end

   always_comb begin
      next_prdata = '0;
      mapped      = 1'b1;
      case (paddr)
         adc_ctrl_pkg::OFS_CTRL_A:    next_prdata = ctrl_a;
         adc_ctrl_pkg::OFS_TRIG_CTRL: next_prdata = trig_ctrl;
         adc_ctrl_pkg::OFS_CMP_CTRL:  next_prdata = cmp_ctrl;
         adc_ctrl_pkg::OFS_CMP_VALUE: next_prdata = 32'(cmp_value);
         adc_ctrl_pkg::OFS_CAL:       next_prdata = 32'(calibration);
         adc_ctrl_pkg::OFS_INT_STAT:  next_prdata = {ready_flag, 20'h00000, int_stat};
         adc_ctrl_pkg::OFS_INT_CLR:   next_prdata = '0;
         adc_ctrl_pkg::OFS_INT_EN:    next_prdata = 32'(int_en);
         default: begin
            mapped = 1'b0;
            for (int i = 0; i < CH; i++) begin
               if (is_addr(paddr, result_addr(i))) begin
                  next_prdata = {ready_flag[i], 19'h00000, result[i]};
                  mapped      = 1'b1;
               end
            end
         end
      endcase
   end

   // no wait state: data captured in setup, answered in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable)
            prdata <= pwrite ? 32'h00000000 : next_prdata;
      end
   end

   // bus handshake
   bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready)
      else $error("bus answer not a single-cycle pulse");
   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> pslverr && pready && prdata == '0)
      else $error("unmapped access not refused");

   // interrupt status
   irq_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
      |(int_stat & int_en) |=> irq)
      else $error("irq not raised for enabled status");
   sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_res.valid && !cmp_ctrl[adc_ctrl_pkg::CMP_EN_LSB + conv_res.channel]
      |=> int_stat[$past(conv_res.channel)])
      else $error("completion not flagged");
   set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
      |set_bits |=> (int_stat & $past(set_bits)) == $past(set_bits))
      else $error("status set lost to a clear");

   // results
   result_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_res.valid |=> result[$past(conv_res.channel)] == $past(conv_res.data))
      else $error("result not stored");
   ready_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_res.valid |=> ready_flag[$past(conv_res.channel)])
      else $error("ready flag not set");

   // conversion requests
   start_issue_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_a[adc_ctrl_pkg::CTRL_ENABLE_BIT] && !trig_ctrl[adc_ctrl_pkg::TRIG_FREE_BIT]
      && |start_bits |-> ##[1:8] conv_req.start)
      else $error("start not issued");
   event_req_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_a[adc_ctrl_pkg::CTRL_ENABLE_BIT] && trigger_event && !event_d |=> |pending)
      else $error("event not taken");
   free_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_a[adc_ctrl_pkg::CTRL_ENABLE_BIT]
       && trig_ctrl[adc_ctrl_pkg::TRIG_FREE_BIT]) [*3] |-> ##1 issue)
      else $error("free run stalled");
   sweep_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      issue && $past(trig_ctrl[adc_ctrl_pkg::TRIG_FREE_BIT])
      |-> issue_ch <= $past(trig_ctrl[adc_ctrl_pkg::TRIG_SWEEP_LSB +: 2]))
      else $error("channel outside sweep group");
   cal_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_req.start |-> conv_req.calibration == $past(calibration))
      else $error("calibration not applied");

   // comparator
   cmp_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_res.valid && cmp_ctrl[adc_ctrl_pkg::CMP_EN_LSB + conv_res.channel]
      |=> !int_stat[$past(conv_res.channel)] || $past(int_stat[conv_res.channel]))
      else $error("completion set while comparing");
   cmp_above_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_res.valid && cmp_ctrl[adc_ctrl_pkg::CMP_EN_LSB + conv_res.channel]
      && cmp_ctrl[adc_ctrl_pkg::CMP_ABOVE_LSB + conv_res.channel] && conv_res.data > cmp_value
      |=> int_stat[adc_ctrl_pkg::INT_CMP_LSB + $past(conv_res.channel)])
      else $error("above-threshold match not flagged");
   cmp_below_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_res.valid && cmp_ctrl[adc_ctrl_pkg::CMP_EN_LSB + conv_res.channel]
      && !cmp_ctrl[adc_ctrl_pkg::CMP_ABOVE_LSB + conv_res.channel] && conv_res.data < cmp_value
      |=> int_stat[adc_ctrl_pkg::INT_CMP_LSB + $past(conv_res.channel)])
      else $error("below-threshold match not flagged");
endmodule
`default_nettype wire

// ==== verification/adc_pipe_model.sv ====
// Purpose: behavioural converter pipeline answering conversion requests
// Assumes: one result per request, returned in request order
// Notes:   idle result lines show the inverse of their last value
`default_nettype none
module adc_pipe_model (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire adc_ctrl_pkg::conv_request_type conv_req,
   input  wire logic                           conv_enable,
   input  wire logic [3:0][11:0]               level,
   input  wire logic [3:0]                     delay,
   output adc_ctrl_pkg::conv_result_type       conv_res,
   output logic                                busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int         due_q[$];
   logic [1:0] ch_q[$];
   int         now;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         due_q = {};
         ch_q = {};
         now = 0;
         conv_res <= '0;
         busy <= 1'b0;
      end else begin
         now++;
         // only an enabled converter accepts work
         if (conv_req.start === 1'b1 && conv_enable === 1'b1) begin
            due_q.push_back(now + int'(delay));
            ch_q.push_back(conv_req.channel);
         end
         if (due_q.size() > 0 && due_q[0] <= now) begin
            conv_res <= {1'b1, ch_q[0], level[ch_q[0]]};
            void'(due_q.pop_front());
            void'(ch_q.pop_front());
         end else begin
            // released lines must not keep a stale value
            conv_res <= {1'b0, ~conv_res.channel, ~conv_res.data};
         end
         busy <= due_q.size() > 0;
      end
   end
endmodule
`default_nettype wire

// ==== verification/adc_sweep_compare_control_tb.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: pipeline model answers in request order
// Notes:   expected values come from a reference model kept here
`default_nettype none
module adc_sweep_compare_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                           pclk, presetn, psel, penable, pwrite;
   logic [7:0]                     paddr;
   logic [31:0]                    pwdata, prdata, rd, seed;
   logic                           pready, pslverr, last_err, trigger_event;
   logic                           conv_enable, irq, busy;
   adc_ctrl_pkg::conv_request_type conv_req;
   adc_ctrl_pkg::conv_result_type  conv_res;
   logic [3:0][11:0]               level;
   logic [3:0]                     delay, cmp_en, above, exp_rdy;
   logic [11:0]                    exp_res[4], cmp_val;
   logic [7:0]                     exp_st;
   logic [15:0]                    cal;
   logic [1:0]                     req_q[$];
   int                             err_total, samples_checked, c;

   adc_sweep_compare_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger_event(trigger_event), .conv_req(conv_req),
      .conv_enable(conv_enable), .conv_res(conv_res), .irq(irq));
   adc_pipe_model pipe (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
      .conv_enable(conv_enable), .level(level), .delay(delay),
      .conv_res(conv_res), .busy(busy));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      check("bus answer wait", n, 1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // a request reaches the pipeline three edges after the write lands
   task automatic settle();
      int n;
      n = 0;
      repeat (5) @(posedge pclk);
      while (busy !== 1'b0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic start(input int ch);
      apb(1'b1, adc_ctrl_pkg::OFS_CTRL_A, 32'h00000001 | (32'h00000004 << ch));
      settle();
   endtask

   task automatic expect_seq(input int first, span, lo, hi);
      check("request count", req_q.size() >= lo && req_q.size() <= hi, 1'b1);
      for (int k = 0; k < req_q.size(); k++)
         check("request channel", req_q[k], first + k % span);
      req_q = {};
   endtask

   task automatic rd_res(input int ch);
      apb(1'b0, adc_ctrl_pkg::OFS_RESULT0 + 8'(4 * ch), '0);
      check("result", rd, {exp_rdy[ch], 19'h00000, exp_res[ch]});
      exp_rdy[ch] = 1'b0;
   endtask

   task automatic stat(input logic irq_exp);
      apb(1'b0, adc_ctrl_pkg::OFS_INT_STAT, '0);
      check("status", rd, {exp_rdy, 20'h00000, exp_st});
      check("interrupt", irq, irq_exp);
   endtask

   always @(posedge pclk) begin
      if (conv_req.start === 1'b1) begin
         req_q.push_back(conv_req.channel);
         check("calibration", conv_req.calibration, cal);
      end
      if (conv_res.valid === 1'b1) begin
         c = int'(conv_res.channel);
         exp_res[c] = conv_res.data;
         exp_rdy[c] = 1'b1;
         if (!cmp_en[c])
            exp_st[c] = 1'b1;
         else if (above[c] ? conv_res.data > cmp_val : conv_res.data < cmp_val)
            exp_st[4 + c] = 1'b1;
      end
   end

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      results();
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, trigger_event} = '0;
      {level, cmp_en, above, exp_rdy, exp_st, cal, cmp_val} = '0;
      delay = 4'h1;
      seed = 32'h86E17661;
      err_total = 0;
      samples_checked = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         if (i != 6) begin
            apb(1'b0, 8'(4 * i), '0);
            check("reset value", rd, '0);
         end
      apb(1'b0, 8'h40, '0);
      check("unmapped error", last_err, 1'b1);
      check("unmapped data", rd, '0);
      seed = lfsr(seed);
      cal = seed[15:0];
      apb(1'b1, adc_ctrl_pkg::OFS_CAL, {16'h0000, cal});
      apb(1'b1, adc_ctrl_pkg::OFS_CTRL_A, 32'h00000001);
      repeat (2) @(posedge pclk);
      check("converter enable", conv_enable, 1'b1);
      // start-up time before the first start
      repeat (24) @(posedge pclk);
      cmp_val = 12'h800;
      cmp_en = 4'hC;
      above = 4'h4;
      apb(1'b1, adc_ctrl_pkg::OFS_INT_EN, 32'h000000FF);
      apb(1'b1, adc_ctrl_pkg::OFS_CMP_VALUE, {20'h00000, cmp_val});
      apb(1'b1, adc_ctrl_pkg::OFS_CMP_CTRL, {24'h000000, above, cmp_en});
      for (int ch = 0; ch < 4; ch++) begin
         seed = lfsr(seed);
         level[ch] <= (seed[11:0] == cmp_val) ? 12'h123 : seed[11:0];
         delay <= 4'(2 * ch + 1);
         start(ch);
         expect_seq(ch, 1, 1, 1);
      end
      level[0] <= ~level[0];
      start(0);
      expect_seq(0, 1, 1, 1);
      stat(|exp_st);
      for (int ch = 0; ch < 4; ch++)
         rd_res(ch);
      apb(1'b1, adc_ctrl_pkg::OFS_INT_EN, '0);
      stat(1'b0);
      apb(1'b1, adc_ctrl_pkg::OFS_TRIG_CTRL, 32'h00000010);
      trigger_event <= 1'b1;
      settle();
      trigger_event <= 1'b0;
      expect_seq(1, 1, 1, 1);
      apb(1'b1, adc_ctrl_pkg::OFS_TRIG_CTRL, 32'h00000034);
      trigger_event <= 1'b1;
      settle();
      trigger_event <= 1'b0;
      expect_seq(0, 3, 3, 3);
      apb(1'b1, adc_ctrl_pkg::OFS_INT_EN, 32'h000000FF);
      stat(1'b1);
      apb(1'b1, adc_ctrl_pkg::OFS_INT_CLR, 32'h000000FF);
      exp_st = '0;
      stat(1'b0);
      // input levels held steady while sweeping
      for (int sel = 0; sel < 4; sel++) begin
         apb(1'b1, adc_ctrl_pkg::OFS_TRIG_CTRL, 32'(2 * sel + 1));
         repeat (12) @(posedge pclk);
         apb(1'b1, adc_ctrl_pkg::OFS_TRIG_CTRL, '0);
         settle();
         expect_seq(0, sel + 1, 8, 40);
      end
      stat(|exp_st);
      results();
   end
endmodule
`default_nettype wire
